// File: core/ecw_consts.vh
// constants for the extender window decode block
`ifndef ECW_CONSTS_VH
`define ECW_CONSTS_VH

// ----------------------------------------------------------------------------
// configuration-space byte offsets
// ----------------------------------------------------------------------------
`define ECW_CFG_WIN_OFF       6'h0a
`define ECW_SHORT_WIN_OFF     6'h0c
`define ECW_STD_WIN_OFF       6'h0e
`define ECW_WIN_COUNT         3

// ----------------------------------------------------------------------------
// access sizes on the configuration port
// ----------------------------------------------------------------------------
`define ECW_SIZE_8            2'h0
`define ECW_SIZE_16           2'h1
`define ECW_SIZE_32           2'h2

// ----------------------------------------------------------------------------
// window register field layout
// ----------------------------------------------------------------------------
`define ECW_FLD_RSVD_ZERO     15
`define ECW_FLD_ENABLE        14
`define ECW_FLD_DIRECTION     13
`define ECW_FLD_RSVD_ONE_HI   12
`define ECW_FLD_RSVD_ONE_LO   11
`define ECW_FLD_SIZE_HI       10
`define ECW_FLD_SIZE_LO       8
`define ECW_FLD_BASE_HI       7
`define ECW_FLD_BASE_LO       0

// bits that hold state; the rest are fixed on read
`define ECW_WIN_STORE_MASK    16'h67ff
// bits 12-11 read as ones, bit 15 as zero
`define ECW_WIN_READ_ONES     16'h1800

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ECW_WIN_RESET         16'h0000

// ----------------------------------------------------------------------------
// address lines
// ----------------------------------------------------------------------------
`define ECW_SHORT_ADDR_HI     15
`define ECW_SHORT_ADDR_LO     8
`define ECW_CFG_QUARTER       2'h3

`endif

// File: core/ecw_window_decode.v
// extender configuration and short-space window registers and decode
`timescale 1ns/1ps
`include "ecw_consts.vh"


module ecw_window_decode (
  // clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire        soft_rst_i,
  // configuration register port
  input  wire        cfg_req_i,
  input  wire        cfg_we_i,
  input  wire [5:0]  cfg_addr_i,
  input  wire [1:0]  cfg_size_i,
  input  wire [31:0] cfg_wdata_i,
  output wire        cfg_ack_o,
  output reg  [31:0] cfg_rdata_o,
  // mode select
  input  wire        compat_layout_select_i,
  // configuration-space lookup
  input  wire        la_req_i,
  input  wire [7:0]  la_addr_i,
  input  wire        la_inward_i,
  input  wire        own_la_hit_i,
  output reg         la_valid_o,
  output reg         cfg_map_o,
  // short-space lookup
  input  wire        short_req_i,
  input  wire [15:0] short_addr_i,
  input  wire        short_inward_i,
  output reg         short_valid_o,
  output reg         short_map_o
);

  // --------------------------------------------------------------------------
  // access classification
  // --------------------------------------------------------------------------
  wire        acc_8;
  wire        acc_16;
  wire        acc_32;
  wire        acc_wr;
  reg         ack_q;
  wire [47:0] rd16_w;
  wire [2:0]  hit_any_w;

  assign acc_8  = cfg_size_i == `ECW_SIZE_8;
  assign acc_16 = cfg_size_i == `ECW_SIZE_16;
  assign acc_32 = cfg_size_i == `ECW_SIZE_32;
  assign acc_wr = cfg_req_i & cfg_we_i;

  // --------------------------------------------------------------------------
  // window registers: staging copy plus active copy
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `ECW_WIN_COUNT; gi = gi + 1) begin : win
      localparam integer OFF_I = 10 + 2 * gi;
      wire [5:0]  off_w;
      wire        hit8h;
      wire        hit8l;
      wire        hit16;
      wire        hit32;
      wire        wr_hi;
      wire        wr_lo;
      wire [15:0] lane_w;
      reg  [7:0]  hi_data;
      reg  [7:0]  lo_data;
      wire [15:0] new_stage;
      reg  [15:0] stage_q;
      reg  [15:0] active_q;

      assign off_w = OFF_I[5:0];
      assign hit8h = acc_8 & (cfg_addr_i == off_w);
      assign hit8l = acc_8 & (cfg_addr_i == (off_w | 6'h01));
      assign hit16 = acc_16 & (cfg_addr_i == off_w);
      // the long word at c carries both the short and standard windows
      assign hit32 = acc_32 & (cfg_addr_i == `ECW_SHORT_WIN_OFF) &
                     (off_w != `ECW_CFG_WIN_OFF);
      assign hit_any_w[gi] = hit8h | hit8l | hit16 | hit32;

      assign lane_w = (off_w == `ECW_SHORT_WIN_OFF) ? cfg_wdata_i[31:16]
                                                    : cfg_wdata_i[15:0];
      always @* begin
        if (acc_8) begin
          hi_data = cfg_wdata_i[7:0];
          lo_data = cfg_wdata_i[7:0];
        end else if (acc_16) begin
          hi_data = cfg_wdata_i[15:8];
          lo_data = cfg_wdata_i[7:0];
        end else begin
          hi_data = lane_w[15:8];
          lo_data = lane_w[7:0];
        end
      end
      assign wr_hi = acc_wr & (hit8h | hit16 | hit32);
      assign wr_lo = acc_wr & (hit8l | hit16 | hit32);

      // fixed bits are dropped on write
      assign new_stage = {wr_hi ? hi_data : stage_q[15:8],
                          wr_lo ? lo_data : stage_q[7:0]} & `ECW_WIN_STORE_MASK;

      // soft reset has no effect on window state
      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          stage_q  <= `ECW_WIN_RESET;
          active_q <= `ECW_WIN_RESET;
        end else begin
          if (wr_hi | wr_lo) begin
            stage_q <= new_stage;
          end
          // upper byte alone only stages; lower byte commits
          if (wr_lo) begin
            active_q <= new_stage;
          end
        end
      end

      // read view: bit 15 zero, bits 12-11 ones
      assign rd16_w[16*gi +: 16] = (stage_q & `ECW_WIN_STORE_MASK) |
                                   `ECW_WIN_READ_ONES;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // register read and acknowledge
  // --------------------------------------------------------------------------
  wire [15:0] rd_cfg;
  wire [15:0] rd_short;
  wire [15:0] rd_std;
  reg  [31:0] rdata_d;
  reg  [15:0] rd_sel;

  assign rd_cfg   = rd16_w[15:0];
  assign rd_short = rd16_w[31:16];
  assign rd_std   = rd16_w[47:32];

  always @* begin
    rd_sel  = 16'h0000;
    if (cfg_addr_i[5:1] == `ECW_CFG_WIN_OFF >> 1) begin
      rd_sel = rd_cfg;
    end else if (cfg_addr_i[5:1] == `ECW_SHORT_WIN_OFF >> 1) begin
      rd_sel = rd_short;
    end else if (cfg_addr_i[5:1] == `ECW_STD_WIN_OFF >> 1) begin
      rd_sel = rd_std;
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    if (hit_any_w == 3'h0) begin
      rdata_d = 32'h0000_0000;
    end else if (acc_32) begin
      rdata_d = {rd_short, rd_std};
    end else if (acc_16) begin
      rdata_d = {16'h0000, rd_sel};
    end else if (cfg_addr_i[0]) begin
      rdata_d = {24'h00_0000, rd_sel[7:0]};
    end else begin
      rdata_d = {24'h00_0000, rd_sel[15:8]};
    end
  end

  // --------------------------------------------------------------------------
  // acknowledge and read data flops
  // --------------------------------------------------------------------------
  // unmapped offsets still answer, reading zero and dropping writes
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cfg_req_i;
    end
  end

  // read data holds until the next read is taken
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rdata_o <= 32'h0000_0000;
    end else if (cfg_req_i & ~cfg_we_i) begin
      cfg_rdata_o <= rdata_d;
    end
  end

  assign cfg_ack_o = ack_q;

  // --------------------------------------------------------------------------
  // active fields
  // --------------------------------------------------------------------------
  wire [15:0] cfg_act;
  wire [15:0] short_act;
  wire        cfg_window_enable;
  wire        cfg_window_direction;
  wire [2:0]  cfg_window_size;
  wire [7:0]  cfg_window_base;
  wire        short_window_enable;
  wire        short_window_direction;
  wire [2:0]  short_window_size;
  wire [7:0]  short_window_base;

  assign cfg_act   = win[0].active_q;
  assign short_act = win[1].active_q;

  assign cfg_window_enable      = cfg_act[`ECW_FLD_ENABLE];
  assign cfg_window_direction   = cfg_act[`ECW_FLD_DIRECTION];
  assign cfg_window_size        = cfg_act[`ECW_FLD_SIZE_HI:`ECW_FLD_SIZE_LO];
  assign cfg_window_base        = cfg_act[`ECW_FLD_BASE_HI:`ECW_FLD_BASE_LO];
  assign short_window_enable    = short_act[`ECW_FLD_ENABLE];
  assign short_window_direction = short_act[`ECW_FLD_DIRECTION];
  assign short_window_size      = short_act[`ECW_FLD_SIZE_HI:`ECW_FLD_SIZE_LO];
  assign short_window_base      = short_act[`ECW_FLD_BASE_HI:`ECW_FLD_BASE_LO];

  // --------------------------------------------------------------------------
  // window match
  // --------------------------------------------------------------------------
  reg  [7:0] cfg_mask;
  reg  [7:0] short_mask;
  wire       cfg_in_range;
  wire       short_in_range;
  wire       short_top_quarter;
  wire [7:0] short_lines;
  wire       cfg_map_d;
  wire       short_map_d;
  wire       cfg_dir_hit;
  wire       short_dir_hit;
  wire       cfg_gate;
  wire       short_gate;

  // --------------------------------------------------------------------------
  // size masks
  // --------------------------------------------------------------------------
  // size field keeps that many base msbs
  always @* begin
    case (cfg_window_size)
      3'h0: cfg_mask = 8'h00;
      3'h1: cfg_mask = 8'h80;
      3'h2: cfg_mask = 8'hc0;
      3'h3: cfg_mask = 8'he0;
      3'h4: cfg_mask = 8'hf0;
      3'h5: cfg_mask = 8'hf8;
      3'h6: cfg_mask = 8'hfc;
      default: cfg_mask = 8'hfe;
    endcase
  end

  always @* begin
    case (short_window_size)
      3'h0: short_mask = 8'h00;
      3'h1: short_mask = 8'h80;
      3'h2: short_mask = 8'hc0;
      3'h3: short_mask = 8'he0;
      3'h4: short_mask = 8'hf0;
      3'h5: short_mask = 8'hf8;
      3'h6: short_mask = 8'hfc;
      default: short_mask = 8'hfe;
    endcase
  end

  // logical address is lines 13 down to 6
  assign cfg_in_range = ((la_addr_i ^ cfg_window_base) & cfg_mask) == 8'h00;

  // base lines up with lines 15 down to 8
  assign short_lines    = short_addr_i[`ECW_SHORT_ADDR_HI:`ECW_SHORT_ADDR_LO];
  assign short_in_range = ((short_lines ^ short_window_base) & short_mask) == 8'h00;

  // top quarter is configuration space
  assign short_top_quarter = short_addr_i[15:14] == `ECW_CFG_QUARTER;

  // range applies in the programmed direction, complement in the other
  assign cfg_dir_hit   = cfg_in_range == (la_inward_i == cfg_window_direction);
  assign short_dir_hit = short_in_range == (short_inward_i == short_window_direction);

  // --------------------------------------------------------------------------
  // window gating
  // --------------------------------------------------------------------------
  assign cfg_gate = ~compat_layout_select_i &
                    cfg_window_enable &
                    ~own_la_hit_i;

  assign short_gate = ~compat_layout_select_i &
                      short_window_enable &
                      ~short_top_quarter;

  assign cfg_map_d   = cfg_gate & cfg_dir_hit;
  assign short_map_d = short_gate & short_dir_hit;

  // --------------------------------------------------------------------------
  // registered decode answers
  // --------------------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      la_valid_o <= 1'b0;
    end else begin
      la_valid_o <= la_req_i;
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_map_o <= 1'b0;
    end else begin
      cfg_map_o <= la_req_i & cfg_map_d;
    end
  end

  // --------------------------------------------------------------------------
  // short-space answers
  // --------------------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      short_valid_o <= 1'b0;
    end else begin
      short_valid_o <= short_req_i;
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      short_map_o <= 1'b0;
    end else begin
      short_map_o <= short_req_i & short_map_d;
    end
  end

endmodule

// File: tb/ecw_chk.sv
// port assertions for the window decode block
`timescale 1ns/1ps
module ecw_chk (
  // clock, reset, register port
  input logic        clock_i,
  input logic        rst_i,
  input logic        cfg_req_i,
  input logic        cfg_we_i,
  input logic [5:0]  cfg_addr_i,
  input logic [1:0]  cfg_size_i,
  input logic        cfg_ack_o,
  input logic [31:0] cfg_rdata_o,
  // lookups
  input logic        compat_layout_select_i,
  input logic        la_req_i,
  input logic        own_la_hit_i,
  input logic        la_valid_o,
  input logic        cfg_map_o,
  input logic        short_req_i,
  input logic [15:0] short_addr_i,
  input logic        short_valid_o,
  input logic        short_map_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (cfg_req_i |=> cfg_ack_o)
    else $error("ack missing");
  a_ack_cause: assert property (cfg_ack_o |-> $past(cfg_req_i))
    else $error("ack without request");
  a_read_fixed: assert property (cfg_req_i && !cfg_we_i && cfg_size_i == 2'h1
    && cfg_addr_i inside {6'h0a, 6'h0c} |=> !cfg_rdata_o[15] && cfg_rdata_o[12:11] == 2'h3)
    else $error("fixed read bits wrong");
  a_wide_read: assert property (cfg_req_i && !cfg_we_i && cfg_size_i == 2'h2
    && cfg_addr_i == 6'h0c |=> !cfg_rdata_o[31] && cfg_rdata_o[28:27] == 2'h3)
    else $error("wide read upper half wrong");
  a_la_answer: assert property (la_req_i |-> ##1 la_valid_o)
    else $error("lookup answer missing");
  a_own_wins: assert property (la_req_i && own_la_hit_i |=> !cfg_map_o)
    else $error("own address mapped");
  a_quarter_out: assert property (short_req_i && short_addr_i[15:14] == 2'h3
    |=> short_valid_o && !short_map_o)
    else $error("upper quarter mapped");
  a_compat_off: assert property (compat_layout_select_i && (la_req_i || short_req_i)
    |=> !cfg_map_o && !short_map_o)
    else $error("map in compat layout");
  a_map_qual: assert property (!short_valid_o |-> !short_map_o)
    else $error("map without valid");
  c_byte_wr: cover property (cfg_req_i && cfg_we_i && cfg_size_i == 2'h0);
  c_cfg_map: cover property (la_valid_o && cfg_map_o);
  c_short_map: cover property (short_valid_o && short_map_o);
endmodule

bind ecw_window_decode ecw_chk ecw_chk_i (.clock_i, .rst_i, .cfg_req_i, .cfg_we_i, .cfg_addr_i,
  .cfg_size_i, .cfg_ack_o, .cfg_rdata_o, .compat_layout_select_i, .la_req_i, .own_la_hit_i,
  .la_valid_o, .cfg_map_o, .short_req_i, .short_addr_i, .short_valid_o, .short_map_o);

// File: tb/ecw_far_master.sv
// far-side master issuing short-space lookups after a gap
`timescale 1ns/1ps
module ecw_far_master (
  // command
  input  wire        clock_i,
  input  wire        go_i,
  input  wire [15:0] addr_i,
  input  wire        inward_i,
  input  wire [3:0]  gap_i,
  // lookup
  output reg         req_o,
  output reg  [15:0] addr_o,
  output reg         inward_o
);
  reg [3:0] cnt_q;
  reg       busy_q;
  wire      fire_w;
  initial {req_o, busy_q, addr_o, inward_o, cnt_q} = 0;
  assign fire_w = ~go_i & busy_q & (cnt_q == 4'h0);
  always @(posedge clock_i) begin
    // idle lines toggle, never stale
    req_o    <= fire_w;
    addr_o   <= fire_w ? addr_i : ~addr_o;
    inward_o <= fire_w ? inward_i : ~inward_o;
    if (go_i) begin
      cnt_q  <= gap_i;
      busy_q <= 1'b1;
    end else if (busy_q && cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    else if (busy_q)
      busy_q <= 1'b0;
  end
endmodule

// File: tb/ecw_window_decode_bench.sv
// self-checking bench for the window decode block
`timescale 1ns/1ps
module ecw_window_decode_bench;
  reg         clock_i, rst_i, soft_rst_i, cfg_req_i, cfg_we_i, go, si, e;
  reg         compat_layout_select_i, la_req_i, la_inward_i, own_la_hit_i;
  reg  [5:0]  cfg_addr_i, o;
  reg  [1:0]  cfg_size_i;
  reg  [31:0] cfg_wdata_i, rd, y;
  reg  [7:0]  la_addr_i;
  reg  [15:0] sa;
  reg  [3:0]  sg;
  reg  [15:0] st [0:2];
  reg  [15:0] cm [0:2];
  wire        cfg_ack_o, la_valid_o, cfg_map_o, short_valid_o, short_map_o;
  wire        short_req_i, short_inward_i;
  wire [31:0] cfg_rdata_o;
  wire [15:0] short_addr_i;
  integer     failures, n_checks, i, j, k;
  ecw_window_decode ecw_window_decode_i (.clock_i, .rst_i, .soft_rst_i, .cfg_req_i, .cfg_we_i,
    .cfg_addr_i, .cfg_size_i, .cfg_wdata_i, .cfg_ack_o, .cfg_rdata_o, .compat_layout_select_i,
    .la_req_i, .la_addr_i, .la_inward_i, .own_la_hit_i, .la_valid_o, .cfg_map_o, .short_req_i,
    .short_addr_i, .short_inward_i, .short_valid_o, .short_map_o);
  ecw_far_master ecw_far_master_i (.clock_i, .go_i(go), .addr_i(sa), .inward_i(si),
    .gap_i(sg), .req_o(short_req_i), .addr_o(short_addr_i), .inward_o(short_inward_i));
  always #10 clock_i = ~clock_i;
  task end_sim;
    begin
      if (failures == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task cmp(input string nm, input [31:0] ex, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== ex) begin
        failures = failures + 1;
        $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  task wt(input [1:0] c);
    begin
      k = 0;
      do begin
        @(negedge clock_i);
        k = k + 1;
      end while ((c == 0 ? cfg_ack_o : c == 1 ? la_valid_o : short_valid_o) !== 1'b1 && k < 40);
      if (k >= 40) begin
        failures = failures + 1;
        end_sim;
      end
    end
  endtask
  function mp(input [15:0] w, input [7:0] a, input d);
    mp = w[14] & (((w[7:0] ^ a) & ~(8'hff >> w[10:8])) == 8'h00) == (d == w[13]);
  endfunction
  task acc(input w, input [5:0] a, input [1:0] s, input [31:0] d);
    begin
      @(posedge clock_i);
      {cfg_req_i, cfg_we_i, cfg_addr_i, cfg_size_i, cfg_wdata_i} <= {1'b1, w, a, s, d};
      @(posedge clock_i);
      cfg_req_i <= 1'b0;
      wt(0);
      rd = cfg_rdata_o;
    end
  endtask
  // register write plus model update
  task wr(input [5:0] a, input [1:0] s, input [31:0] d);
    integer x;
    begin
      acc(1'b1, a, s, d);
      x = (a - 6'h0a) >> 1;
      if (s == 2'h2)
        {st[1], st[2], cm[1], cm[2]} = {d, d};
      else if (s == 2'h1 || a[0])
        {st[x], cm[x]} = s[0] ? {d[15:0], d[15:0]} : {st[x][15:8], d[7:0], st[x][15:8], d[7:0]};
      else
        st[x][15:8] = d[7:0];
    end
  endtask
  task rchk;
    begin
      for (j = 0; j < 3; j = j + 1) begin
        acc(1'b0, 6'h0a + 2 * j, 2'h1, 0);
        cmp("window", st[j] & 16'h67ff | 16'h1800, rd);
      end
      acc(1'b0, 6'h0c, 2'h2, 0);
      cmp("wide", {st[1], st[2]} & 32'h67ff67ff | 32'h18001800, rd);
    end
  endtask
  task lk(input [31:0] v);
    begin
      @(posedge clock_i);
      {la_req_i, la_addr_i, la_inward_i, own_la_hit_i, go} <= {1'b1, v[7:0], v[8], v[9] & v[10],
                                                               1'b1};
      {sa, si, sg} <= {v[31:16], v[11], v[15:12]};
      @(posedge clock_i);
      {la_req_i, go} <= 2'b00;
      wt(1);
      e = mp(cm[0], v[7:0], v[8]) & ~(v[9] & v[10]) & ~compat_layout_select_i;
      cmp("cfg_map", e, cfg_map_o);
      wt(2);
      e = mp(cm[1], v[31:24], v[11]) & (v[31:30] != 2'h3) & ~compat_layout_select_i;
      cmp("short_map", e, short_map_o);
    end
  endtask
  initial begin
    rst_i = 1'b1;
    {clock_i, soft_rst_i, cfg_req_i, cfg_we_i, go, si, compat_layout_select_i, la_req_i,
     la_inward_i, own_la_hit_i, cfg_addr_i, cfg_size_i, cfg_wdata_i, la_addr_i, sa, sg} = 0;
    {failures, n_checks, st[0], st[1], st[2], cm[0], cm[1], cm[2]} = 0;
    k = $urandom(32'h6e3b);
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    rchk;
    wr(6'h0c, 2'h1, 32'h4000);
    lk(32'hc5000000);
    lk(32'h85000000);
    for (i = 0; i < 60; i = i + 1) begin
      y = $urandom;
      o = 6'h0a + {y[1:0] % 2'h3, 1'b0};
      if (y[2])
        wr(6'h0c, 2'h2, $urandom);
      else if (y[3]) begin
        wr(o, 2'h0, y[15:8]);
        lk($urandom);
        wr(o | 6'h01, 2'h0, y[23:16]);
      end else
        wr(o, 2'h1, $urandom);
      rchk;
      lk($urandom);
    end
    acc(1'b0, 6'h02, 2'h1, 0);
    cmp("unmapped", 0, rd);
    soft_rst_i <= 1'b1;
    lk($urandom);
    soft_rst_i <= 1'b0;
    rchk;
    compat_layout_select_i <= 1'b1;
    repeat (6) lk($urandom);
    compat_layout_select_i <= 1'b0;
    @(posedge clock_i);
    rst_i <= 1'b1;
    @(posedge clock_i);
    rst_i <= 1'b0;
    {st[0], st[1], st[2], cm[0], cm[1], cm[2]} = 0;
    rchk;
    lk($urandom);
    end_sim;
  end
endmodule
